// ===== design/serial_pkg.sv
// Shared constants and carriers for the asynchronous serial transceiver
package serial_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned TICKS_PER_BIT = 16;
    localparam logic [4:0]  BIT_LAST_TICK = 5'h0f;
    localparam logic [4:0]  LEAD_LAST_TICK = 5'h10;
    localparam logic [3:0]  RX_MID_TICK   = 4'h7;
    localparam logic [3:0]  RX_LAST_TICK  = 4'hf;
    localparam logic [2:0]  LAST_DATA_BIT = 3'h7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] DIVISOR_RESET  = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic        LINE_IDLE      = 1'b1;

    // ****************************************************************
    // Address-matching schemes
    // ****************************************************************
    localparam logic [1:0] SCHEME_ALL       = 2'b00;
    localparam logic [1:0] SCHEME_ADDR_ONLY = 2'b01;
    localparam logic [1:0] SCHEME_MATCHED   = 2'b10;
    localparam logic [1:0] SCHEME_DATA_ONLY = 2'b11;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_LEAD  = 3'b001,
        TX_START = 3'b010,
        TX_DATA  = 3'b011,
        TX_NINTH = 3'b100,
        TX_STOP  = 3'b101
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_NINTH = 3'b011,
        RX_STOP  = 3'b100
    } rx_state_e;

    // Character format shared by both directions
    typedef struct packed {
        logic       parity_on_bit;
        logic       parity_odd;
        logic       two_stop;
        logic       multidrop_enable;
        logic [1:0] multidrop_scheme_select;
    } frame_cfg_s;

    // Receive status
    typedef struct packed {
        logic framing_err;
        logic parity_err;
        logic overrun_err;
        logic break_seen;
        logic new_frame;
        logic rx_ninth;
    } rx_status_s;

endpackage

// ===== design/async_serial_transceiver.sv
// Full-duplex asynchronous serial transmitter, receiver and bit rate divider
module async_serial_transceiver (
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    input  wire serial_pkg::frame_cfg_s cfg_i,
    input  wire logic                   tx_enable_bit_i,
    input  wire logic                   rx_enable_i,
    input  wire logic                   flow_control_enable_i,
    input  wire logic                   tx_ninth_bit_i,
    input  wire logic                   rx_irq_errors_only_i,
    input  wire logic                   timer_mode_i,
    input  wire logic [7:0]             divisor_byte_i,
    input  wire logic                   divisor_hi_wr_i,
    input  wire logic                   divisor_lo_wr_i,
    input  wire logic [7:0]             addr_compare_i,
    input  wire logic [7:0]             tx_data_i,
    input  wire logic                   tx_data_wr_i,
    input  wire logic                   rx_data_rd_i,
    input  wire logic                   rxd_i,
    input  wire logic                   cts_n_i,
    output logic                        txd_o,
    output logic                        transceiver_drive_enable_o,
    output logic                        tx_holding_empty_o,
    output logic                        tx_irq_o,
    output logic                        rx_byte_ready_o,
    output logic [7:0]                  rx_data_o,
    output serial_pkg::rx_status_s      rx_status_o,
    output logic                        rx_irq_o,
    output logic                        timer_irq_o
);
    import serial_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic       rxd_meta;
    logic       rxd_sync;
    logic       cts_n_meta;
    logic       cts_n_sync;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rxd_meta   <= LINE_IDLE;
            rxd_sync   <= LINE_IDLE;
            cts_n_meta <= 1'b1;
            cts_n_sync <= 1'b1;
        end else begin
            rxd_meta   <= rxd_i;
            rxd_sync   <= rxd_meta;
            cts_n_meta <= cts_n_i;
            cts_n_sync <= cts_n_meta;
        end
    end

    // ****************************************************************
    // Bit rate divider and timer
    // ****************************************************************
    logic [15:0] divisor;
    logic [15:0] div_cnt;
    logic        tick;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            divisor <= DIVISOR_RESET;
        end else begin
            if (divisor_hi_wr_i) begin
                divisor[15:8] <= divisor_byte_i;
            end
            if (divisor_lo_wr_i) begin
                divisor[7:0] <= divisor_byte_i;
            end
        end
    end

    // One tick per divisor count, sixteen ticks per bit
    assign tick = (div_cnt <= 16'h0001);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_cnt <= DIVISOR_RESET;
        end else if (tick) begin
            div_cnt <= divisor;
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    // timer pulse when serial use is off
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_irq_o <= 1'b0;
        end else begin
            timer_irq_o <= timer_mode_i & ~tx_enable_bit_i & ~rx_enable_i
                           & tick;
        end
    end

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    tx_state_e  tx_state;
    logic [4:0] tx_ph;
    logic [2:0] tx_bit;
    logic       tx_stop2;
    logic [7:0] hold_data;
    logic       hold_ninth;
    logic       hold_full;
    logic [7:0] tx_shift;
    logic       tx_ninth;
    logic       tx_bit_end;
    logic       tx_lead_end;
    logic       can_send;
    logic       has_ninth;

    assign tx_bit_end  = tick & (tx_ph == BIT_LAST_TICK);
    assign tx_lead_end = tick & (tx_ph == LEAD_LAST_TICK);
    assign has_ninth   = cfg_i.multidrop_enable | cfg_i.parity_on_bit;
    // clear-to-send ignored unless flow control is on
    // sampled in the cycle that starts a character
    assign can_send    = hold_full & tx_enable_bit_i
                         & (~flow_control_enable_i | ~cts_n_sync);

    // holding register and its empty flag
    // a write fills it and clears the empty flag
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hold_data  <= BYTE_RESET;
            hold_ninth <= 1'b0;
            hold_full  <= 1'b0;
        end else if (tx_data_wr_i) begin
            hold_data  <= tx_data_i;
            // marker bit captured with the byte
            hold_ninth <= tx_ninth_bit_i;
            hold_full  <= 1'b1;
        end else if (tx_state == TX_START && tx_ph == 5'h00 && hold_full
                     && tick) begin
            hold_full  <= 1'b0;
        end
    end

    // shifter loads from holding register on its own
    // transmit sequencing independent of the receiver
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_state <= TX_IDLE;
            tx_ph    <= 5'h00;
            tx_bit   <= 3'h0;
            tx_stop2 <= 1'b0;
            tx_shift <= BYTE_RESET;
            tx_ninth <= 1'b0;
        end else begin
            if (tick) begin
                tx_ph <= (tx_bit_end && tx_state != TX_LEAD) ? 5'h00
                                                              : tx_ph + 5'h01;
            end
            unique case (tx_state)
                TX_IDLE: begin
                    tx_ph <= 5'h00;
                    if (hold_full && tx_enable_bit_i) begin
                        tx_state <= TX_LEAD;
                    end
                end
                TX_LEAD: begin
                    if (tx_lead_end) begin
                        tx_ph <= LEAD_LAST_TICK;
                    end
                    if (tx_ph == LEAD_LAST_TICK && can_send) begin
                        tx_state <= TX_START;
                        tx_ph    <= 5'h00;
                    end
                end
                TX_START: begin
                    if (tick && tx_ph == 5'h00) begin
                        tx_shift <= hold_data;
                        // even or odd parity on send
                        // marker bit in place of parity
                        tx_ninth <= cfg_i.multidrop_enable ? hold_ninth
                                  : (^hold_data) ^ cfg_i.parity_odd;
                    end
                    if (tx_bit_end) begin
                        tx_state <= TX_DATA;
                        tx_bit   <= 3'h0;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit   <= tx_bit + 3'h1;
                        if (tx_bit == LAST_DATA_BIT) begin
                            tx_state <= has_ninth ? TX_NINTH : TX_STOP;
                            tx_stop2 <= 1'b0;
                        end
                    end
                end
                TX_NINTH: begin
                    if (tx_bit_end) begin
                        tx_state <= TX_STOP;
                        tx_stop2 <= 1'b0;
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end) begin
                        if (cfg_i.two_stop && !tx_stop2) begin
                            tx_stop2 <= 1'b1;
                        end else if (can_send) begin
                            tx_state <= TX_START;
                        end else begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // Line, drive enable and transmit interrupt
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            txd_o                      <= LINE_IDLE;
            transceiver_drive_enable_o <= 1'b0;
            tx_holding_empty_o         <= 1'b1;
            tx_irq_o                   <= 1'b0;
        end else begin
            unique case (tx_state)
                TX_START: txd_o <= 1'b0;
                TX_DATA:  txd_o <= tx_shift[0];
                TX_NINTH: txd_o <= tx_ninth;
                default:  txd_o <= LINE_IDLE;
            endcase
            // drive enable covers lead, frame and stop
            // drops one clock after the last stop bit
            transceiver_drive_enable_o <= (tx_state != TX_IDLE);
            tx_holding_empty_o         <= ~hold_full;
            // raised while enabled and holding register empty
            tx_irq_o <= tx_enable_bit_i & ~hold_full;
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    rx_state_e  rx_state;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic       rx_ninth;
    logic       rx_sample;
    logic       rx_done;
    logic       is_addr;
    logic       addr_hit;
    logic       matched;
    logic       first_data;
    logic       accept;
    logic       par_bad;
    logic       frame_bad;
    logic       brk;

    // centre sampling after the mid-bit start check
    assign rx_sample = tick & (rx_ph == RX_LAST_TICK);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_state <= RX_IDLE;
            rx_ph    <= 4'h0;
            rx_bit   <= 3'h0;
            rx_shift <= BYTE_RESET;
            rx_ninth <= 1'b0;
        end else if (!rx_enable_i) begin
            rx_state <= RX_IDLE;
            rx_ph    <= 4'h0;
        end else begin
            if (tick) begin
                rx_ph <= rx_ph + 4'h1;
            end
            unique case (rx_state)
                RX_IDLE: begin
                    rx_ph <= 4'h0;
                    if (!rxd_sync) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick && rx_ph == RX_MID_TICK) begin
                        rx_ph    <= 4'h0;
                        rx_bit   <= 3'h0;
                        rx_state <= rxd_sync ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift <= {rxd_sync, rx_shift[7:1]};
                        rx_bit   <= rx_bit + 3'h1;
                        if (rx_bit == LAST_DATA_BIT) begin
                            rx_state <= has_ninth ? RX_NINTH : RX_STOP;
                        end
                    end
                end
                RX_NINTH: begin
                    if (rx_sample) begin
                        rx_ninth <= rxd_sync;
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    assign rx_done   = rx_enable_i & (rx_state == RX_STOP) & rx_sample;
    assign is_addr   = cfg_i.multidrop_enable & rx_ninth;
    // address compare against the node address
    assign addr_hit  = (rx_shift == addr_compare_i);
    assign par_bad   = cfg_i.parity_on_bit & ~cfg_i.multidrop_enable
                       & (rx_ninth != ((^rx_shift) ^ cfg_i.parity_odd));
    // a low stop bit is a framing error
    assign frame_bad = ~rxd_sync;
    assign brk       = frame_bad & (rx_shift == BYTE_RESET)
                       & (~has_ninth | ~rx_ninth);

    // scheme select decides which bytes are taken
    always_comb begin
        accept = 1'b1;
        if (cfg_i.multidrop_enable) begin
            unique case (cfg_i.multidrop_scheme_select)
                SCHEME_ALL:       accept = 1'b1;
                SCHEME_ADDR_ONLY: accept = is_addr;
                SCHEME_MATCHED:   accept = is_addr ? addr_hit : matched;
                SCHEME_DATA_ONLY: accept = ~is_addr & matched;
            endcase
        end
    end

    // frame match tracking and first-data marker
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            matched    <= 1'b0;
            first_data <= 1'b0;
        end else if (rx_done && cfg_i.multidrop_enable) begin
            if (is_addr) begin
                matched    <= addr_hit;
                first_data <= addr_hit;
            end else if (accept) begin
                first_data <= 1'b0;
            end
        end
    end

    // receive data register and ready flag
    // error flags; a new event wins over the read clear
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_byte_ready_o <= 1'b0;
            rx_data_o       <= BYTE_RESET;
            rx_status_o     <= '0;
        end else begin
            if (rx_data_rd_i) begin
                rx_byte_ready_o         <= 1'b0;
                rx_status_o.framing_err <= 1'b0;
                rx_status_o.parity_err  <= 1'b0;
                rx_status_o.overrun_err <= 1'b0;
                rx_status_o.break_seen  <= 1'b0;
            end
            if (rx_done) begin
                if (frame_bad) begin
                    rx_status_o.framing_err <= 1'b1;
                end
                if (par_bad) begin
                    rx_status_o.parity_err <= 1'b1;
                end
                if (brk) begin
                    rx_status_o.break_seen <= 1'b1;
                end
                if (accept) begin
                    if (rx_byte_ready_o && !rx_data_rd_i) begin
                        rx_status_o.overrun_err <= 1'b1;
                    end
                    rx_byte_ready_o       <= 1'b1;
                    rx_data_o             <= rx_shift;
                    rx_status_o.rx_ninth  <= rx_ninth;
                    rx_status_o.new_frame <= first_data & ~is_addr;
                end
            end
        end
    end

    // data plus errors, or errors alone
    // one interrupt for data and error sources
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_irq_o <= 1'b0;
        end else begin
            rx_irq_o <= (rx_byte_ready_o & ~rx_irq_errors_only_i)
                        | rx_status_o.framing_err | rx_status_o.parity_err
                        | rx_status_o.overrun_err | rx_status_o.break_seen;
        end
    end

endmodule

// ===== testbench/serial_chk.sv
// Port-level assertions for the asynchronous serial transceiver
module serial_chk (
    input wire logic                   sys_clk_i,
    input wire logic                   reset_i,
    input wire logic                   tx_enable_bit_i,
    input wire logic                   rx_enable_i,
    input wire logic                   rx_irq_errors_only_i,
    input wire logic                   timer_mode_i,
    input wire logic                   tx_data_wr_i,
    input wire logic                   rx_data_rd_i,
    input wire logic                   txd_o,
    input wire logic                   transceiver_drive_enable_o,
    input wire logic                   tx_holding_empty_o,
    input wire logic                   tx_irq_o,
    input wire logic                   rx_byte_ready_o,
    input wire serial_pkg::rx_status_s rx_status_o,
    input wire logic                   rx_irq_o,
    input wire logic                   timer_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Line held idle from drive enable rise
    sequence s_lead_quiet;
        txd_o [*8];
    endsequence

    a_de_covers_frame: assert property (
        !txd_o |-> transceiver_drive_enable_o) else $error("low without DE");
    a_de_lead_idle: assert property (
        $rose(transceiver_drive_enable_o) |-> s_lead_quiet)
        else $error("DE lead too short");
    a_de_after_stop: assert property (
        $fell(transceiver_drive_enable_o) |-> $past(txd_o, 8) && txd_o)
        else $error("DE dropped inside frame");
    a_write_clears_empty: assert property (
        tx_data_wr_i |-> ##2 !tx_holding_empty_o)
        else $error("empty flag not cleared");
    a_tx_irq_ready: assert property (
        (tx_enable_bit_i && tx_holding_empty_o && !tx_data_wr_i) [*3]
        |-> tx_irq_o) else $error("tx irq missing");
    a_read_clears_ready: assert property (
        rx_data_rd_i |=> !rx_byte_ready_o) else $error("ready not cleared");
    a_data_irq_follows: assert property (
        $rose(rx_byte_ready_o) && !rx_irq_errors_only_i |=> rx_irq_o)
        else $error("rx irq missing");
    a_err_irq_cause: assert property (
        $rose(rx_irq_o) && rx_irq_errors_only_i |-> rx_status_o.framing_err
        || rx_status_o.parity_err || rx_status_o.overrun_err)
        else $error("errors-only irq without error");
    a_break_is_framing: assert property (
        rx_status_o.break_seen |-> rx_status_o.framing_err)
        else $error("break without framing error");
    a_timer_gated: assert property (
        timer_irq_o |-> $past(timer_mode_i) && !$past(tx_enable_bit_i)
        && !$past(rx_enable_i)) else $error("timer pulse while serial on");
endmodule

bind async_serial_transceiver serial_chk i_chk (.*);

// ===== testbench/serial_peer.sv
// Remote serial node model on the far side of the line
module serial_peer #(
    parameter int BIT_CLKS = 32
) (
    input  wire logic sys_clk_i,
    input  wire logic txd_i,
    output logic      rxd_o,
    output logic      cts_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rxd_o = 1'b1;
        cts_n_o = 1'b0;
    end
    task automatic send(input logic [8:0] v, input int n, input logic stp);
        rxd_o = 1'b0;
        repeat (BIT_CLKS) @(negedge sys_clk_i);
        for (int i = 0; i <= n; i++) begin
            rxd_o = (i == n) ? stp : v[i];
            repeat (BIT_CLKS) @(negedge sys_clk_i);
        end
        rxd_o = 1'b1;
        repeat (BIT_CLKS) @(negedge sys_clk_i);
    endtask
    task automatic recv(input int n, output logic [9:0] v);
        v = '1;
        @(negedge txd_i);
        repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
        for (int i = 0; i <= n; i++) begin
            repeat (BIT_CLKS) @(posedge sys_clk_i);
            v[i] = txd_i;
        end
    endtask
endmodule

// ===== testbench/async_serial_transceiver_tb_top.sv
// Self-checking bench for the asynchronous serial transceiver
module async_serial_transceiver_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       reset_i = 1'b1;
    frame_cfg_s cfg_i = '0;
    logic       tx_enable_bit_i = 1'b0;
    logic       rx_enable_i = 1'b0;
    logic       flow_control_enable_i = 1'b0;
    logic       tx_ninth_bit_i = 1'b0;
    logic       rx_irq_errors_only_i = 1'b0;
    logic       timer_mode_i = 1'b0;
    logic       divisor_hi_wr_i = 1'b0;
    logic       divisor_lo_wr_i = 1'b0;
    logic       tx_data_wr_i = 1'b0;
    logic       rx_data_rd_i = 1'b0;
    logic [7:0] divisor_byte_i = 8'h00;
    logic [7:0] addr_compare_i = 8'h5a;
    logic [7:0] tx_data_i = 8'h00;
    logic       rxd_i, cts_n_i, txd_o, transceiver_drive_enable_o;
    logic       tx_holding_empty_o, tx_irq_o, rx_byte_ready_o;
    logic       rx_irq_o, timer_irq_o;
    logic [7:0] rx_data_o, d;
    rx_status_s rx_status_o;
    logic [9:0] got;
    logic [11:0] tbl [7] = '{12'h144, 12'h433, 12'h733, 12'ha33, 12'h811,
                            12'hb5a, 12'hd22};
    int         bad_count = 0;
    int         samples_checked = 0;
    int         cnt;

    always #5 sys_clk_i = ~sys_clk_i;
    async_serial_transceiver i_dut (.*);
    serial_peer #(.BIT_CLKS(32)) i_peer (.sys_clk_i, .txd_i(txd_o),
        .rxd_o(rxd_i), .cts_n_o(cts_n_i));

    task automatic check(input string what, input logic [9:0] got_v, exp);
        samples_checked++;
        if (got_v !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got_v);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk_i);
        s = 1'b0;
    endtask
    // Write one character and catch it on the line
    task automatic tx(input logic [8:0] v, input int n);
        tx_data_i = v[7:0];
        tx_ninth_bit_i = v[8];
        fork
            i_peer.recv(n, got);
            begin
                pulse(tx_data_wr_i);
                @(negedge sys_clk_i);
                check("empty", tx_holding_empty_o, 0);
            end
        join
    endtask

    initial begin
        #500_000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (21) @(negedge sys_clk_i);
        reset_i = 1'b0;
        check("idle", {txd_o, transceiver_drive_enable_o, tx_holding_empty_o,
            rx_byte_ready_o}, 4'b1010);
        pulse(divisor_hi_wr_i);
        divisor_byte_i = 8'h02;
        pulse(divisor_lo_wr_i);
        {tx_enable_bit_i, rx_enable_i, i_peer.cts_n_o} = 3'b111;
        cfg_i.parity_on_bit = 1'b1;
        cfg_i.two_stop = 1'b1;
        for (int p = 0; p < 2; p++) begin
            cfg_i.parity_odd = p[0];
            d = 8'h4b + 8'(p);
            fork
                tx({1'b0, d}, 9);
                i_peer.send({^d ^ p[0], d}, 9, 1'b1);
            join
            check("tx frame", got, {1'b1, ^d ^ p[0], d});
            check("tx irq", tx_irq_o, 1);
            check("rx", {rx_byte_ready_o, rx_status_o.parity_err, rx_data_o},
                {2'b10, d});
            check("rx irq", rx_irq_o, 1);
            pulse(rx_data_rd_i);
        end
        rx_irq_errors_only_i = 1'b1;
        i_peer.send({^d, d}, 9, 1'b1);
        check("par err", {rx_status_o.parity_err, rx_irq_o}, 3);
        pulse(rx_data_rd_i);
        i_peer.send({~^d, d}, 9, 1'b1);
        check("quiet", {rx_byte_ready_o, rx_irq_o}, 2);
        i_peer.send({~^d, d}, 9, 1'b1);
        check("overrun", {rx_status_o.overrun_err, rx_irq_o}, 3);
        pulse(rx_data_rd_i);
        i_peer.send(9'h000, 9, 1'b0);
        check("break", {rx_status_o.framing_err, rx_status_o.break_seen},
            3);
        pulse(rx_data_rd_i);
        {rx_irq_errors_only_i, rx_enable_i} = 2'b00;
        i_peer.send({~^d, d}, 9, 1'b1);
        check("rx off", rx_byte_ready_o, 0);
        {rx_enable_i, flow_control_enable_i} = 2'b11;
        tx_data_i = 8'hc3;
        pulse(tx_data_wr_i);
        cnt = 0;
        repeat (128) begin
            @(negedge sys_clk_i);
            if (txd_o !== 1'b1) cnt++;
        end
        check("cts hold", 10'(cnt), 0);
        check("cts de", transceiver_drive_enable_o, 1);
        i_peer.cts_n_o = 1'b0;
        i_peer.recv(9, got);
        check("cts frame", got, {1'b1, ~^8'hc3, 8'hc3});
        {cfg_i.parity_on_bit, cfg_i.multidrop_enable} = 2'b01;
        tx(9'h1a7, 9);
        check("ninth", got, {1'b1, 9'h1a7});
        foreach (tbl[i]) begin
            cfg_i.multidrop_scheme_select = tbl[i][11:10];
            i_peer.send({tbl[i][9], tbl[i][7:0]}, 9, 1'b1);
            check("scheme", rx_byte_ready_o, tbl[i][8]);
            pulse(rx_data_rd_i);
        end
        check("new frame", {rx_status_o.new_frame, rx_status_o.rx_ninth},
            2);
        {tx_enable_bit_i, rx_enable_i, timer_mode_i} = 3'b001;
        repeat (4) @(negedge sys_clk_i);
        cnt = 0;
        repeat (64) begin
            @(negedge sys_clk_i);
            if (timer_irq_o === 1'b1) cnt++;
        end
        check("timer", 10'(cnt), 32);
        give_verdict();
    end
endmodule
